// File: hdl/pmr_pkg.sv
// Constants, register map and carrier types for the PCS management register set.
// Assumes a single 40 MHz system clock and an MDIO frame engine in front of the bank.
package pmr_pkg;

  localparam logic [4:0]  REG_PCS_CONTROL      = 5'h00;
  localparam logic [4:0]  REG_PCS_STATUS       = 5'h01;
  localparam logic [4:0]  REG_PHY_IDENT_UPPER  = 5'h02;
  localparam logic [4:0]  REG_PHY_IDENT_LOWER  = 5'h03;
  localparam logic [4:0]  REG_AN_ADVERTISEMENT = 5'h04;
  localparam logic [4:0]  REG_LINK_PARTNER     = 5'h05;
  localparam logic [4:0]  REG_AN_EXPANSION     = 5'h06;
  localparam logic [4:0]  REG_NP_TRANSMIT      = 5'h07;
  localparam logic [4:0]  REG_NP_RECEIVE       = 5'h08;
  localparam logic [4:0]  REG_EXT_STATUS       = 5'h0f;
  localparam logic [4:0]  REG_AN_INT_CONTROL   = 5'h10;
  localparam logic [4:0]  REG_LOOPBACK_POS     = 5'h11;

  // Control register fields
  localparam int          CTL_RESET_BIT        = 15;
  localparam int          CTL_LOOPBACK_BIT     = 14;
  localparam int          CTL_AN_ENABLE_BIT    = 12;
  localparam int          CTL_POWER_DOWN_BIT   = 11;
  localparam int          CTL_ISOLATE_BIT      = 10;
  localparam int          CTL_AN_RESTART_BIT   = 9;
  localparam int          CTL_UNIDIR_BIT       = 5;
  localparam logic [15:0] CTL_WRITABLE_MASK    = 16'hde20;
  localparam logic [15:0] CTL_FIXED_ONES       = 16'h0140;
  localparam logic [15:0] CTL_RESET_VALUE      = 16'h1400;

  // Status register fields
  localparam int          STS_AN_COMPLETE_BIT  = 5;
  localparam int          STS_REMOTE_FAULT_BIT = 4;
  localparam int          STS_LINK_STATUS_BIT  = 2;
  localparam logic [15:0] STS_FIXED_ONES       = 16'h01c8;

  // Identifier values are arbitrary neutral codes
  localparam logic [15:0] IDENT_UPPER_VALUE    = 16'h0000;
  localparam logic [15:0] IDENT_LOWER_VALUE    = 16'h0000;

  localparam logic [15:0] ADVERTISEMENT_VALUE  = 16'h0001;
  localparam logic [15:0] PARTNER_RESET_VALUE  = 16'h8001;
  localparam logic [15:0] PARTNER_VALID_MASK   = 16'hdc00;
  localparam logic [15:0] PARTNER_FIXED_ONES   = 16'h0001;
  localparam int          EXP_PAGE_RX_BIT      = 1;
  localparam logic [15:0] EXP_FIXED_ONES       = 16'h0004;

  localparam logic [15:0] NPT_WRITABLE_MASK    = 16'hb7ff;
  localparam logic [15:0] NPT_RESET_VALUE      = 16'h2001;
  localparam int          NPT_TOGGLE_BIT       = 11;

  localparam int          NPR_ACK2_BIT         = 12;
  localparam int          NPR_TOGGLE_BIT       = 11;
  localparam logic [15:0] NPR_VALID_MASK       = 16'hffff;
  localparam logic [15:0] NPR_RESET_VALUE      = 16'h0000;

  localparam logic [15:0] EXT_STATUS_VALUE     = 16'h8000;

  localparam int          INT_STATUS_BIT       = 1;
  localparam int          INT_ENABLE_BIT       = 0;
  localparam logic        INT_ENABLE_RESET     = 1'b1;
  localparam int          LBP_POSITION_BIT     = 0;
  localparam logic        LBP_POSITION_RESET   = 1'b0;

  // Idle code group sent while looped inside the PCS, loopback position 0 (K28.5 / D16.2 pair)
  localparam logic [7:0]  IDLE_K_CHAR          = 8'hbc;
  localparam logic [7:0]  IDLE_D_CHAR          = 8'h50;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmr_mgmt_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } pmr_mgmt_rsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic       is_k;
  } pmr_symbol_t;

  typedef struct packed {
    logic        an_complete;
    logic        link_up;
    logic        remote_fault;
    logic        page_rx;
    logic [15:0] partner_word;
    logic        np_rx;
    logic [15:0] np_word;
  } pmr_an_event_t;

endpackage

// File: hdl/pmr_register_set.sv
// PCS management register bank reached by register address from an MDIO frame engine,
// with the loopback point at the transceiver side of the PCS (position 0, with idle insertion) or inside the transceiver (position 1).
// Assumes requests and auto-negotiation events are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pmr_register_set
  import pmr_pkg::*;
(
  input  wire logic          clk_sys,         // System clock, 40 MHz
  input  wire logic          nrst,            // Asynchronous reset, active low
  input  wire logic          sgmii_sel,       // SGMII physical interface selected
  input  wire pmr_mgmt_req_t mgmt_req,        // Management read/write request
  output pmr_mgmt_rsp_t      mgmt_rsp,        // Read data answer
  input  wire pmr_an_event_t an_evt,          // Auto-negotiation results from PCS
  input  wire pmr_symbol_t   pcs_tx_sym,      // Transmit code group from PCS
  input  wire pmr_symbol_t   serdes_rx_sym,   // Receive code group from transceiver
  output pmr_symbol_t        serdes_tx_sym,   // Code group toward transceiver
  output pmr_symbol_t        pcs_rx_sym,      // Code group toward PCS receive
  output logic               an_irq,          // Completion interrupt to MAC status
  output logic               serdes_lpbk,     // Loopback inside transceiver
  output logic               pcs_reset,       // Self-clearing PCS reset pulse
  output logic               an_restart,      // Self-clearing restart pulse
  output logic               an_enable,       // Auto-negotiation enabled
  output logic               power_down,      // Transceiver low power request
  output logic               isolate,         // Isolate the PCS
  output logic               unidir_en        // Unidirectional transmit enable
);

  logic        rst_meta_q;
  logic        rst_sync_q;
  logic        rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  logic [15:0] ctl_q,       ctl_d;
  logic [15:0] partner_q,   partner_d;
  logic [15:0] npt_q,       npt_d;
  logic [15:0] npr_q,       npr_d;
  logic        an_done_q,   an_done_d;
  logic        rfault_q,    rfault_d;
  logic        link_q,      link_d;
  logic        page_rx_q,   page_rx_d;
  logic        int_en_q,    int_en_d;
  logic        int_sts_q,   int_sts_d;
  logic        lbp_pos_q,   lbp_pos_d;
  logic [15:0] rdata_q,     rdata_d;
  logic        rvalid_q;
  pmr_symbol_t tx_sym_q,    tx_sym_d;
  pmr_symbol_t rx_sym_q,    rx_sym_d;
  logic        idle_phase_q;

  // Register selection shared by reads and writes
  function automatic logic hit(input pmr_mgmt_req_t r, input logic [4:0] a);
    return r.addr == a;
  endfunction

  wire         wr_ctl     = mgmt_req.wr & hit(mgmt_req, REG_PCS_CONTROL);
  wire         wr_npt     = mgmt_req.wr & hit(mgmt_req, REG_NP_TRANSMIT);
  wire         wr_int     = mgmt_req.wr & hit(mgmt_req, REG_AN_INT_CONTROL);
  wire         wr_lbp     = mgmt_req.wr & hit(mgmt_req, REG_LOOPBACK_POS);
  wire         rd_sts     = mgmt_req.rd & hit(mgmt_req, REG_PCS_STATUS);
  wire         rd_exp     = mgmt_req.rd & hit(mgmt_req, REG_AN_EXPANSION);
  wire         loop_on    = ctl_q[CTL_LOOPBACK_BIT];
  wire         loop_soft  = loop_on & ~lbp_pos_q;

  // Writable fields only; fixed and reserved bits never stored
  wire [15:0]  ctl_wr_val = (mgmt_req.wdata & CTL_WRITABLE_MASK);
  wire [15:0]  npt_wr_val = (mgmt_req.wdata & NPT_WRITABLE_MASK) |
                            (npt_q & ~NPT_WRITABLE_MASK);

  always_comb begin
    ctl_d = ctl_q;
    ctl_d[CTL_RESET_BIT]      = 1'b0;
    ctl_d[CTL_AN_RESTART_BIT] = 1'b0;
    if (wr_ctl) begin
      ctl_d = ctl_wr_val;
    end
    if (ctl_q[CTL_RESET_BIT]) begin
      ctl_d[CTL_POWER_DOWN_BIT] = 1'b0;
    end
  end

  always_comb begin
    partner_d = partner_q;
    if (an_evt.an_complete) begin
      partner_d = (an_evt.partner_word & PARTNER_VALID_MASK) | PARTNER_FIXED_ONES;
    end
  end

  always_comb begin
    npt_d = npt_q;
    if (wr_npt) begin
      npt_d = npt_wr_val;
    end
    if (an_evt.np_rx) begin
      npt_d[NPT_TOGGLE_BIT] = ~npt_q[NPT_TOGGLE_BIT];
    end
  end

  always_comb begin
    npr_d = npr_q;
    if (an_evt.np_rx) begin
      npr_d = an_evt.np_word & NPR_VALID_MASK;
    end
  end

  // Sticky status flags: a new event wins over the clear by restart or reset (completion) or by read (others)
  always_comb begin
    an_done_d = an_done_q;
    if (ctl_q[CTL_AN_RESTART_BIT] || ctl_q[CTL_RESET_BIT]) begin
      an_done_d = 1'b0;
    end
    if (an_evt.an_complete) begin
      an_done_d = 1'b1;
    end
  end

  always_comb begin
    rfault_d = rd_sts ? 1'b0 : rfault_q;
    link_d   = rd_sts ? 1'b0 : link_q;
    if (an_evt.remote_fault) begin
      rfault_d = 1'b1;
    end
    if (an_evt.link_up) begin
      link_d = 1'b1;
    end
    page_rx_d = rd_exp ? 1'b0 : page_rx_q;
    if (an_evt.page_rx) begin
      page_rx_d = 1'b1;
    end
  end

  always_comb begin
    int_en_d  = wr_int ? mgmt_req.wdata[INT_ENABLE_BIT] : int_en_q;
    int_sts_d = int_sts_q;
    if (wr_int && !mgmt_req.wdata[INT_STATUS_BIT]) begin
      int_sts_d = 1'b0;
    end
    if (an_evt.an_complete) begin
      int_sts_d = 1'b1;
    end
    if (!int_en_d) begin
      int_sts_d = 1'b0;
    end
    lbp_pos_d = wr_lbp ? mgmt_req.wdata[LBP_POSITION_BIT] : lbp_pos_q;
  end

  // Read mux; unmapped addresses and non-SGMII mode read zero
  always_comb begin
    rdata_d = 16'h0000;
    case (mgmt_req.addr)
      REG_PCS_CONTROL:      rdata_d = ctl_q | CTL_FIXED_ONES;
      REG_PCS_STATUS:       rdata_d = STS_FIXED_ONES |
                                      (16'(an_done_q) << STS_AN_COMPLETE_BIT) |
                                      (16'(rfault_q)  << STS_REMOTE_FAULT_BIT) |
                                      (16'(link_q)    << STS_LINK_STATUS_BIT);
      REG_PHY_IDENT_UPPER:  rdata_d = IDENT_UPPER_VALUE;
      REG_PHY_IDENT_LOWER:  rdata_d = IDENT_LOWER_VALUE;
      REG_AN_ADVERTISEMENT: rdata_d = ADVERTISEMENT_VALUE;
      REG_LINK_PARTNER:     rdata_d = partner_q;
      REG_AN_EXPANSION:     rdata_d = EXP_FIXED_ONES | (16'(page_rx_q) << EXP_PAGE_RX_BIT);
      REG_NP_TRANSMIT:      rdata_d = npt_q;
      REG_NP_RECEIVE:       rdata_d = npr_q;
      REG_EXT_STATUS:       rdata_d = EXT_STATUS_VALUE;
      REG_AN_INT_CONTROL:   rdata_d = (16'(int_sts_q) << INT_STATUS_BIT) |
                                      (16'(int_en_q)  << INT_ENABLE_BIT);
      REG_LOOPBACK_POS:     rdata_d = 16'(lbp_pos_q) << LBP_POSITION_BIT;
      default:              rdata_d = 16'h0000;
    endcase
    if (!sgmii_sel) begin
      rdata_d = 16'h0000;
    end
  end

  // Idle ordered set alternates comma and data characters
  always_comb begin
    tx_sym_d = pcs_tx_sym;
    rx_sym_d = serdes_rx_sym;
    if (loop_soft) begin
      rx_sym_d = pcs_tx_sym;
    end
    if (loop_soft) begin
      tx_sym_d.is_k = ~idle_phase_q;
      tx_sym_d.data = idle_phase_q ? IDLE_D_CHAR : IDLE_K_CHAR;
    end
  end

  // Control word; reset and restart bits clear themselves a cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= CTL_RESET_VALUE;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      partner_q <= PARTNER_RESET_VALUE;
    end else begin
      partner_q <= partner_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      npt_q <= NPT_RESET_VALUE;
    end else begin
      npt_q <= npt_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      npr_q <= NPR_RESET_VALUE;
    end else begin
      npr_q <= npr_d;
    end
  end

  // Sticky event flags; an event in the cycle of a clear wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      an_done_q <= 1'b0;
    end else begin
      an_done_q <= an_done_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rfault_q <= 1'b0;
    end else begin
      rfault_q <= rfault_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_rx_q <= 1'b0;
    end else begin
      page_rx_q <= page_rx_d;
    end
  end

  // Interrupt enable and status, loopback position
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_en_q <= INT_ENABLE_RESET;
    end else begin
      int_en_q <= int_en_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_sts_q <= 1'b0;
    end else begin
      int_sts_q <= int_sts_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lbp_pos_q <= LBP_POSITION_RESET;
    end else begin
      lbp_pos_q <= lbp_pos_d;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= mgmt_req.rd ? rdata_d : rdata_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= mgmt_req.rd;
    end
  end

  // One cycle of latency on both code group paths
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_sym_q <= '0;
    end else begin
      tx_sym_q <= tx_sym_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sym_q <= '0;
    end else begin
      rx_sym_q <= rx_sym_d;
    end
  end

  // Idle phase restarts on the comma whenever loopback starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_phase_q <= 1'b0;
    end else begin
      idle_phase_q <= loop_soft ? ~idle_phase_q : 1'b0;
    end
  end

  assign mgmt_rsp.valid = rvalid_q;
  assign mgmt_rsp.rdata = rdata_q;
  assign serdes_tx_sym  = tx_sym_q;
  assign pcs_rx_sym     = rx_sym_q;
  assign an_irq         = int_sts_q;
  assign serdes_lpbk    = loop_on & lbp_pos_q;
  assign pcs_reset      = ctl_q[CTL_RESET_BIT];
  assign an_restart     = ctl_q[CTL_AN_RESTART_BIT];
  assign an_enable      = ctl_q[CTL_AN_ENABLE_BIT];
  assign power_down     = ctl_q[CTL_POWER_DOWN_BIT];
  assign isolate        = ctl_q[CTL_ISOLATE_BIT];
  assign unidir_en      = ctl_q[CTL_UNIDIR_BIT];

endmodule

`default_nettype wire

// File: dv/pmr_register_set_chk.sv
// Port assertions for the PCS management register bank.
// Assumes one clock domain; bound to the bank by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module pmr_register_set_chk
  import pmr_pkg::*;
(
  input wire logic          clk_sys,        // System clock
  input wire logic          nrst,           // Reset, active low
  input wire logic          sgmii_sel,      // SGMII selected
  input wire pmr_mgmt_req_t mgmt_req,       // Management requests
  input wire pmr_mgmt_rsp_t mgmt_rsp,       // Read answers
  input wire pmr_an_event_t an_evt,         // Negotiation events
  input wire pmr_symbol_t   serdes_tx_sym,  // Code group toward transceiver
  input wire logic          an_irq,         // Completion interrupt
  input wire logic          serdes_lpbk     // Loop inside transceiver
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_loop_on;
    mgmt_req.wr && mgmt_req.addr == REG_PCS_CONTROL && mgmt_req.wdata[14] && !mgmt_req.wdata[15];
  endsequence
  sequence s_idle_out;
    serdes_lpbk || serdes_tx_sym == 9'h179 || serdes_tx_sym == 9'h0a0;
  endsequence
  sequence s_irq_wr_zero;
    mgmt_req.wr && mgmt_req.addr == REG_AN_INT_CONTROL && !mgmt_req.wdata[1] && !an_evt.an_complete;
  endsequence

  a_rd_answer: assert property (mgmt_req.rd |=> mgmt_rsp.valid)
    else $error("read not answered next cycle");
  a_no_spurious: assert property (mgmt_rsp.valid |-> $past(mgmt_req.rd))
    else $error("answer without a read");
  a_ext_fixed: assert property ((mgmt_req.rd && mgmt_req.addr == REG_EXT_STATUS && sgmii_sel) ##1 sgmii_sel
    |-> mgmt_rsp.rdata == 16'h8000) else $error("extended status value wrong");
  a_intctl_resvd: assert property (mgmt_req.rd && mgmt_req.addr == REG_AN_INT_CONTROL
    |=> mgmt_rsp.rdata[15:2] == 14'h0000) else $error("interrupt control reserved bits set");
  a_irq_cause: assert property ($rose(an_irq) |-> $past(an_evt.an_complete))
    else $error("interrupt rose without completion");
  a_irq_sticky: assert property (an_irq && !mgmt_req.wr |=> an_irq)
    else $error("interrupt status dropped without a write");
  a_irq_wr_clear: assert property (s_irq_wr_zero |=> !an_irq)
    else $error("interrupt status not cleared by write");
  a_loop_idles: assert property (s_loop_on |=> ##1 s_idle_out)
    else $error("no idle toward transceiver in loopback");
  a_lpbk_cause: assert property ($rose(serdes_lpbk) |-> $past(mgmt_req.wr))
    else $error("transceiver loop changed without a write");
endmodule

bind pmr_register_set pmr_register_set_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .sgmii_sel(sgmii_sel), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
  .an_evt(an_evt), .serdes_tx_sym(serdes_tx_sym), .an_irq(an_irq), .serdes_lpbk(serdes_lpbk)
);
`default_nettype wire

// File: dv/pmr_mgmt_model.sv
// Management master model: single register reads and writes by address.
// Assumes the read answer arrives one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module pmr_mgmt_model
  import pmr_pkg::*;
(
  input  wire logic          clk_sys,   // System clock
  output var pmr_mgmt_req_t  mgmt_req,  // Request toward the bank
  input  wire pmr_mgmt_rsp_t mgmt_rsp   // Answer from the bank
);
  initial mgmt_req = '0;

  // Released address and data are inverted so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys); #1;
    mgmt_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys); #1;
    mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys); #1;
    mgmt_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk_sys); #1;
    mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
    @(negedge clk_sys);
    d = mgmt_rsp.rdata;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_pmr_register_set.sv
// Self-checking bench for the management register bank.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_pmr_register_set
  import pmr_pkg::*;
;
  logic          clk_sys, nrst, sgmii_sel, an_irq, serdes_lpbk;
  logic          pcs_reset, an_restart, an_enable, power_down, isolate, unidir_en;
  pmr_mgmt_req_t mgmt_req;
  pmr_mgmt_rsp_t mgmt_rsp;
  pmr_an_event_t an_evt;
  pmr_symbol_t   pcs_tx_sym, serdes_rx_sym, serdes_tx_sym, pcs_rx_sym, s0, s1;
  int            error_cnt, cmp_count;
  logic [15:0]   rv;

  pmr_register_set u_pmr_register_set (.clk_sys(clk_sys), .nrst(nrst), .sgmii_sel(sgmii_sel),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp), .an_evt(an_evt), .pcs_tx_sym(pcs_tx_sym),
    .serdes_rx_sym(serdes_rx_sym), .serdes_tx_sym(serdes_tx_sym), .pcs_rx_sym(pcs_rx_sym),
    .an_irq(an_irq), .serdes_lpbk(serdes_lpbk), .pcs_reset(pcs_reset), .an_restart(an_restart),
    .an_enable(an_enable), .power_down(power_down), .isolate(isolate), .unidir_en(unidir_en));
  pmr_mgmt_model u_pmr_mgmt_model (.clk_sys(clk_sys), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    u_pmr_mgmt_model.rd(a, rv);
    chk(rv, e);
  endtask

  task automatic ev(input logic c, input logic np, input logic [15:0] w);
    @(posedge clk_sys); #1;
    an_evt = '{an_complete: c, link_up: 1'b0, remote_fault: 1'b0, page_rx: 1'b0,
               partner_word: w, np_rx: np, np_word: w};
    @(posedge clk_sys); #1;
    an_evt = '0;
    @(negedge clk_sys);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    nrst = 1'b0;
    sgmii_sel = 1'b1;
    an_evt = '0;
    pcs_tx_sym = 9'h0aa;
    serdes_rx_sym = 9'h133;
    repeat (6) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rc(REG_EXT_STATUS, 16'h8000);
    rc(REG_AN_INT_CONTROL, 16'h0001);
    rc(REG_NP_RECEIVE, 16'h0000);
    rc(REG_LOOPBACK_POS, 16'h0000);
    rc(REG_PCS_CONTROL, 16'h1540);
    rc(REG_PCS_STATUS, 16'h01c8);
    rc(5'h09, 16'h0000);
    chk({14'h0000, an_enable, isolate}, 16'h0003);
    u_pmr_mgmt_model.wr(REG_EXT_STATUS, 16'hffff);
    u_pmr_mgmt_model.wr(REG_NP_RECEIVE, 16'hffff);
    u_pmr_mgmt_model.wr(REG_AN_INT_CONTROL, 16'hffff);
    rc(REG_EXT_STATUS, 16'h8000);
    rc(REG_NP_RECEIVE, 16'h0000);
    rc(REG_AN_INT_CONTROL, 16'h0001);
    $display("test reset values and fixed bits done");
    ev(1'b0, 1'b1, 16'h1abc);
    rc(REG_NP_RECEIVE, 16'h1abc);
    ev(1'b0, 1'b1, 16'h0801);
    rc(REG_NP_RECEIVE, 16'h0801);
    ev(1'b1, 1'b0, 16'hd8ff);
    chk({15'h0000, an_irq}, 16'h0001);
    rc(REG_AN_INT_CONTROL, 16'h0003);
    rc(REG_PCS_STATUS, 16'h01e8);
    rc(REG_LINK_PARTNER, 16'hd801);
    u_pmr_mgmt_model.wr(REG_AN_INT_CONTROL, 16'h0001);
    chk({15'h0000, an_irq}, 16'h0000);
    u_pmr_mgmt_model.wr(REG_AN_INT_CONTROL, 16'h0000);
    ev(1'b1, 1'b0, 16'hd8ff);
    chk({15'h0000, an_irq}, 16'h0000);
    rc(REG_AN_INT_CONTROL, 16'h0000);
    u_pmr_mgmt_model.wr(REG_AN_INT_CONTROL, 16'h0001);
    $display("test next page and interrupt done");
    u_pmr_mgmt_model.wr(REG_LOOPBACK_POS, 16'h0001);
    chk({15'h0000, serdes_lpbk}, 16'h0000);
    u_pmr_mgmt_model.wr(REG_PCS_CONTROL, 16'h4000);
    chk({15'h0000, serdes_lpbk}, 16'h0001);
    u_pmr_mgmt_model.wr(REG_LOOPBACK_POS, 16'h0000);
    chk({15'h0000, serdes_lpbk}, 16'h0000);
    rc(REG_PCS_CONTROL, 16'h4140);
    s0 = serdes_tx_sym;
    @(negedge clk_sys);
    s1 = serdes_tx_sym;
    chk({7'h00, s0.is_k ? s0 : s1}, 16'h0179);
    chk({7'h00, s0.is_k ? s1 : s0}, 16'h00a0);
    chk({7'h00, pcs_rx_sym}, 16'h00aa);
    u_pmr_mgmt_model.wr(REG_PCS_CONTROL, 16'h0000);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, serdes_tx_sym}, 16'h00aa);
    chk({7'h00, pcs_rx_sym}, 16'h0133);
    $display("test loopback done");
    u_pmr_mgmt_model.wr(REG_PCS_CONTROL, 16'h0a20);
    chk({12'h000, pcs_reset, an_restart, power_down, unidir_en}, 16'h0007);
    rc(REG_PCS_STATUS, 16'h01c8);
    chk({12'h000, pcs_reset, an_restart, power_down, unidir_en}, 16'h0003);
    u_pmr_mgmt_model.wr(REG_PCS_CONTROL, 16'h8800);
    chk({12'h000, pcs_reset, an_restart, power_down, unidir_en}, 16'h000a);
    @(posedge clk_sys);
    #1;
    chk({12'h000, pcs_reset, an_restart, power_down, unidir_en}, 16'h0000);
    an_evt.link_up = 1'b1;
    @(posedge clk_sys);
    #1 an_evt.link_up = 1'b0;
    rc(REG_PCS_STATUS, 16'h01cc);
    rc(REG_PCS_STATUS, 16'h01c8);
    $display("test control pulses and link status done");
    @(posedge clk_sys);
    #1 sgmii_sel = 1'b0;
    rc(REG_EXT_STATUS, 16'h0000);
    @(posedge clk_sys);
    #1 sgmii_sel = 1'b1;
    rc(REG_EXT_STATUS, 16'h8000);
    $display("test interface select done");
    test_done();
  end
endmodule
`default_nettype wire
